/* File: pgc_global_config.sv */
// Global configuration registers and factory option logic of the power manager.
// Assumes the serial protocol engine presents decoded register accesses as
// one-cycle strobes on the system clock; pins arrive asynchronously.
`timescale 1ns/10ps
`default_nettype none
module pgc_global_config
	import pgc_pkg::*;
#(
	parameter logic       OPT_SLOW_CLOCK_OPEN_DRAIN = 1'b0,
	parameter logic       OPT_WAKE_ZERO_ACTIVE_LOW  = 1'b0,
	parameter logic       OPT_WAKE_ONE_ACTIVE_LOW   = 1'b0,
	parameter logic       OPT_ADAPTER_ACTIVE_LOW    = 1'b0,
	parameter logic       OPT_COVER_ACTIVE_LOW      = 1'b0,
	parameter logic       OPT_POWER_DOWN_ACTIVE_LOW = 1'b0,
	parameter logic       OPT_WD_ENABLE_LOCK        = 1'b0,
	parameter logic       OPT_WD_PERIOD_LOCK        = 1'b0,
	parameter logic [1:0] OPT_RELEASE_DELAY         = 2'h0,
	parameter logic       OPT_MANUAL_RESET_REWAKE   = 1'b0,
	parameter logic [7:0] OPT_CFG1_RESET            = 8'h80,
	parameter logic       OPT_WD_ENABLE_RESET       = 1'b0,
	parameter logic [7:0] SERIAL_NUMBER_LOW         = 8'h5A, // Arbitrary value
	parameter int         DELAY_CYC_0               = PGC_RELEASE_CYC_0,
	parameter int         DELAY_CYC_1               = PGC_RELEASE_CYC_1,
	parameter int         DELAY_CYC_2               = PGC_RELEASE_CYC_2,
	parameter int         DELAY_CYC_3               = PGC_RELEASE_CYC_3
)
(
	input  wire logic       i_clk_sys,
	input  wire logic       i_arst_n,
	// Decoded register accesses from the serial engine
	input  wire logic [6:0] i_bus_dev_addr,
	input  wire logic [7:0] i_bus_reg_addr,
	input  wire logic       i_bus_wr,
	input  wire logic       i_bus_rd,
	input  wire logic [7:0] i_bus_wdata,
	output logic [7:0]      o_bus_rdata,
	output logic            o_bus_ack,
	// Raw pins and analog levels
	input  wire logic       i_wake_input_zero,
	input  wire logic       i_wake_input_one,
	input  wire logic       i_adapter_present_input,
	input  wire logic       i_cover_closed_input,
	input  wire logic       i_power_down_input,
	input  wire logic       i_battery_below_threshold,
	input  wire logic       i_slow_clock,
	input  wire logic       i_bidir_reset_line_i,
	output logic            o_bidir_reset_line_o,
	output logic            o_bidir_reset_line_oe,
	output logic            o_slow_clock_output_o,
	output logic            o_slow_clock_output_oe,
	// System events
	input  wire logic       i_reset_request,
	input  wire logic       i_global_shutdown,
	input  wire logic       i_power_off_function,
	input  wire logic       i_manual_reset_shutdown,
	input  wire logic       i_battery_flag_clear,
	// Qualified inputs for the on/off controller
	output logic            o_wake_zero_active,
	output logic            o_wake_one_active,
	output logic            o_adapter_present,
	output logic            o_cover_closed,
	output logic            o_power_down_request,
	// Status and controls
	output logic            o_battery_low_status,
	output logic            o_battery_low_interrupt_flag,
	output logic            o_global_shutdown_request,
	output logic            o_self_wake,
	output logic            o_reset_line_level,
	output logic [1:0]      o_battery_hysteresis,
	output logic [2:0]      o_battery_threshold,
	output logic            o_watchdog_enable,
	output logic [1:0]      o_watchdog_period
);

	typedef struct packed
	{
		logic [PGC_SYNC_WIDTH-1:0] s1;
		logic [PGC_SYNC_WIDTH-1:0] s2;
		logic                      batt_prev;
		logic [7:0]                cfg1;
		logic                      wd_en;
		logic [1:0]                wd_period;
		logic                      batt_flag;
		logic                      shutdown_req;
		logic                      self_wake;
		logic [7:0]                rdata;
		logic                      ack;
		logic [PGC_POL_WIDTH-1:0]  pol;
	} pgc_top_regs_t;

	// Option-dependent reset values are constants of elaboration
	localparam logic [7:0] CFG1_RESET = (PGC_CFG1_FIXED_RESET & PGC_CFG1_FIXED_MASK)
		| (OPT_CFG1_RESET & ~PGC_CFG1_FIXED_MASK);
	localparam logic [PGC_POL_WIDTH-1:0] POL_OPTS = {OPT_POWER_DOWN_ACTIVE_LOW,
		OPT_COVER_ACTIVE_LOW, OPT_ADAPTER_ACTIVE_LOW, OPT_WAKE_ONE_ACTIVE_LOW,
		OPT_WAKE_ZERO_ACTIVE_LOW};
	localparam pgc_top_regs_t TOP_RESET = '{
		s1: '0, s2: '0, batt_prev: 1'b0,
		cfg1: CFG1_RESET,
		wd_en: OPT_WD_ENABLE_RESET,
		wd_period: PGC_WD_PER_RESET,
		batt_flag: 1'b0, shutdown_req: 1'b0, self_wake: 1'b0,
		rdata: PGC_ZERO_BYTE, ack: 1'b0, pol: '0};

	pgc_top_regs_t r;
	pgc_top_regs_t next_r;
	logic [PGC_SYNC_WIDTH-1:0] pins;
	logic                      selected;
	logic                      batt_low;
	logic                      write_cfg1;
	logic                      write_wdog;
	logic                      want_clear;
	logic                      period_ok;

	pgc_delay_if dly ();

	// Release timer for the bidirectional reset line
	pgc_release_timer #(
		.DELAY_CYC_0 (DELAY_CYC_0),
		.DELAY_CYC_1 (DELAY_CYC_1),
		.DELAY_CYC_2 (DELAY_CYC_2),
		.DELAY_CYC_3 (DELAY_CYC_3)
	) u_release_timer (
		.i_clk_sys (i_clk_sys),
		.i_arst_n  (i_arst_n),
		.dly       (dly.timer)
	);

	// Gather asynchronous levels into the synchroniser vector
	always_comb
	begin
		pins                   = '0;
		pins[PGC_IN_WAKE0]     = i_wake_input_zero;
		pins[PGC_IN_WAKE1]     = i_wake_input_one;
		pins[PGC_IN_ADAPTER]   = i_adapter_present_input;
		pins[PGC_IN_COVER]     = i_cover_closed_input;
		pins[PGC_IN_PWRDN]     = i_power_down_input;
		pins[PGC_IN_BATT_LOW]  = i_battery_below_threshold;
		pins[PGC_IN_RST_LINE]  = i_bidir_reset_line_i;
		pins[PGC_IN_SLOW_CLK]  = i_slow_clock;
	end

	// Access decode; other slave addresses belong to other blocks
	assign selected   = (i_bus_dev_addr == PGC_DEV_ADDR);
	assign write_cfg1 = selected && i_bus_wr && (i_bus_reg_addr == PGC_CFG1_ADDR);
	assign write_wdog = selected && i_bus_wr && (i_bus_reg_addr == PGC_WDOG_ADDR);
	assign batt_low   = r.s2[PGC_IN_BATT_LOW];
	assign want_clear = !i_bus_wdata[PGC_WD_EN_BIT];
	// Period lock looks at the enable as it stood before this write
	assign period_ok  = !OPT_WD_PERIOD_LOCK || !r.wd_en;

	// Next-state logic of the whole block
	always_comb
	begin
		next_r           = r;
		next_r.s1        = pins;
		next_r.s2        = r.s1;
		next_r.batt_prev = batt_low;

		// Polarity applied after synchronising; factory bit 1 inverts
		next_r.pol = r.s2[PGC_IN_PWRDN:PGC_IN_WAKE0] ^ POL_OPTS;

		// global_config_one: every bit stored as written
		if (write_cfg1)
			next_r.cfg1 = i_bus_wdata;

		// Watchdog enable: the lock option refuses a clear once set
		if (write_wdog)
		begin
			if (!OPT_WD_ENABLE_LOCK)
				next_r.wd_en = i_bus_wdata[PGC_WD_EN_BIT];
			else if (!(r.wd_en && want_clear))
				next_r.wd_en = i_bus_wdata[PGC_WD_EN_BIT];
			if (period_ok)
				next_r.wd_period = i_bus_wdata[PGC_WD_PER_MSB:PGC_WD_PER_LSB];
		end
		// Shutdown and power-off outrank any enable write in the same cycle; a period write still lands
		if (i_global_shutdown || i_power_off_function)
			next_r.wd_en = 1'b0;

		// Battery flag: a new edge wins over a clear in the same cycle
		if (i_battery_flag_clear)
			next_r.batt_flag = 1'b0;
		if (batt_low && !r.batt_prev)
			next_r.batt_flag = 1'b1;

		// Shutdown request on a rising battery-low edge, only when enabled
		next_r.shutdown_req = batt_low && !r.batt_prev && r.cfg1[PGC_BATTERY_LOW_POWER_DOWN_BIT_BIT];

		// Own wake after a manual-reset shutdown when the option asks for it
		next_r.self_wake = i_manual_reset_shutdown && OPT_MANUAL_RESET_REWAKE;

		// Read data and acknowledge, one cycle after the strobe
		next_r.ack   = selected && (i_bus_wr || i_bus_rd);
		next_r.rdata = PGC_ZERO_BYTE;
		if (selected && i_bus_rd)
		begin
			case (i_bus_reg_addr)
				PGC_CFG1_ADDR:   next_r.rdata = r.cfg1;
				PGC_WDOG_ADDR:
				begin
					next_r.rdata[PGC_WD_EN_BIT]                 = r.wd_en;
					next_r.rdata[PGC_WD_PER_MSB:PGC_WD_PER_LSB] = r.wd_period;
				end
				PGC_SERIAL_ADDR: next_r.rdata = SERIAL_NUMBER_LOW;
				default:         next_r.rdata = PGC_ZERO_BYTE;
			endcase
		end
	end

	// Single state register; factory options are parameters and never written
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			r <= TOP_RESET;
		else
			r <= next_r;
	end

	// Reset line held by a request or by a routed low battery
	assign dly.hold       = i_reset_request || (r.cfg1[PGC_ROUTE_BIT] && batt_low);
	assign dly.delay_code = OPT_RELEASE_DELAY;

	// Reset line is open-drain: drive low only
	assign o_bidir_reset_line_o  = 1'b0;
	assign o_bidir_reset_line_oe = dly.line_low;

	// Slow clock stage; open-drain only ever pulls low, so data is fixed at zero
	assign o_slow_clock_output_o  = OPT_SLOW_CLOCK_OPEN_DRAIN ? 1'b0
		: r.s2[PGC_IN_SLOW_CLK];
	assign o_slow_clock_output_oe = OPT_SLOW_CLOCK_OPEN_DRAIN ? !r.s2[PGC_IN_SLOW_CLK]
		: 1'b1;

	// Register-sourced outputs
	assign o_bus_rdata                  = r.rdata;
	assign o_bus_ack                    = r.ack;
	assign o_wake_zero_active           = r.pol[PGC_IN_WAKE0];
	assign o_wake_one_active            = r.pol[PGC_IN_WAKE1];
	assign o_adapter_present            = r.pol[PGC_IN_ADAPTER];
	assign o_cover_closed               = r.pol[PGC_IN_COVER];
	assign o_power_down_request         = r.pol[PGC_IN_PWRDN];
	assign o_battery_low_status         = batt_low;
	assign o_battery_low_interrupt_flag = r.batt_flag;
	assign o_global_shutdown_request    = r.shutdown_req;
	assign o_self_wake                  = r.self_wake;
	assign o_reset_line_level           = r.s2[PGC_IN_RST_LINE];
	assign o_battery_hysteresis         = r.cfg1[PGC_HYST_MSB:PGC_HYST_LSB];
	assign o_battery_threshold          = r.cfg1[PGC_THR_MSB:PGC_THR_LSB];
	assign o_watchdog_enable            = r.wd_en;
	assign o_watchdog_period            = r.wd_period;

endmodule
`default_nettype wire

/* File: pgc_pkg.sv */
// Package for the global configuration and factory option block.
// Assumes a single 100 MHz system clock; shared by the top and the release timer.
package pgc_pkg;

	// Register map and serial slave address
	localparam logic [6:0] PGC_DEV_ADDR    = 7'h3C;
	localparam logic [7:0] PGC_CFG1_ADDR   = 8'h00;
	localparam logic [7:0] PGC_WDOG_ADDR   = 8'h01;
	localparam logic [7:0] PGC_SERIAL_ADDR = 8'h58;

	// Field positions of global_config_one
	localparam int PGC_RSVD_BIT   = 7;
	localparam int PGC_BATTERY_LOW_POWER_DOWN_BIT_BIT  = 6;
	localparam int PGC_HYST_LSB   = 4;
	localparam int PGC_HYST_MSB   = 5;
	localparam int PGC_THR_LSB    = 1;
	localparam int PGC_THR_MSB    = 3;
	localparam int PGC_ROUTE_BIT  = 0;

	// Field positions of the watchdog control register
	localparam int PGC_WD_EN_BIT  = 2;
	localparam int PGC_WD_PER_LSB = 0;
	localparam int PGC_WD_PER_MSB = 1;

	// Reset values: fixed bits under mask, the rest come from factory options
	localparam logic [7:0] PGC_CFG1_FIXED_MASK  = 8'h32;
	localparam logic [7:0] PGC_CFG1_FIXED_RESET = 8'h12;
	localparam logic [1:0] PGC_WD_PER_RESET     = 2'h3;
	localparam logic [7:0] PGC_ZERO_BYTE        = 8'h00;

	// Index of each input in the synchroniser vector
	localparam int PGC_SYNC_WIDTH  = 8;
	localparam int PGC_IN_WAKE0    = 0;
	localparam int PGC_IN_WAKE1    = 1;
	localparam int PGC_IN_ADAPTER  = 2;
	localparam int PGC_IN_COVER    = 3;
	localparam int PGC_IN_PWRDN    = 4;
	localparam int PGC_IN_BATT_LOW = 5;
	localparam int PGC_IN_RST_LINE = 6;
	localparam int PGC_IN_SLOW_CLK = 7;
	localparam int PGC_POL_WIDTH   = 5;

	// Reset release delays, in milliseconds as printed, and their cycle counts
	localparam real PGC_CLK_PERIOD_NS = 10.0;
	localparam real PGC_RELEASE_MS_0  = 1.28;
	localparam real PGC_RELEASE_MS_1  = 10.24;
	localparam real PGC_RELEASE_MS_2  = 40.96;
	localparam real PGC_RELEASE_MS_3  = 81.92;
	localparam int  PGC_RELEASE_CYC_0 = int'($ceil(PGC_RELEASE_MS_0 * 1.0e6 / PGC_CLK_PERIOD_NS));
	localparam int  PGC_RELEASE_CYC_1 = int'($ceil(PGC_RELEASE_MS_1 * 1.0e6 / PGC_CLK_PERIOD_NS));
	localparam int  PGC_RELEASE_CYC_2 = int'($ceil(PGC_RELEASE_MS_2 * 1.0e6 / PGC_CLK_PERIOD_NS));
	localparam int  PGC_RELEASE_CYC_3 = int'($ceil(PGC_RELEASE_MS_3 * 1.0e6 / PGC_CLK_PERIOD_NS));
	localparam int  PGC_DELAY_WIDTH   = 24;

	// Release delay codes
	localparam logic [1:0] PGC_DLY_CODE_0 = 2'h0;
	localparam logic [1:0] PGC_DLY_CODE_1 = 2'h1;
	localparam logic [1:0] PGC_DLY_CODE_2 = 2'h2;

	// Release timer states
	typedef enum logic [2:0]
	{
		PGC_TM_IDLE  = 3'b001,
		PGC_TM_HOLD  = 3'b010,
		PGC_TM_COUNT = 3'b100
	} pgc_tm_state_t;

endpackage

/* File: pgc_delay_if.sv */
// Interface between the configuration top and the reset release timer.
// Assumes both ends run on the system clock.
`timescale 1ns/10ps
`default_nettype none
interface pgc_delay_if;
	logic       hold;       // Reset held by some source
	logic [1:0] delay_code; // Factory release delay selection
	logic       line_low;   // Timer wants the reset line pulled low

	modport ctrl
	(
		output hold,
		output delay_code,
		input  line_low
	);

	modport timer
	(
		input  hold,
		input  delay_code,
		output line_low
	);
endinterface
`default_nettype wire

/* File: pgc_release_timer.sv */
// Reset release timer: keeps the reset line low while held, then for the chosen delay.
// Assumes hold is a synchronous level on the system clock.
`timescale 1ns/10ps
`default_nettype none
module pgc_release_timer
	import pgc_pkg::*;
#(
	parameter int DELAY_CYC_0 = PGC_RELEASE_CYC_0,
	parameter int DELAY_CYC_1 = PGC_RELEASE_CYC_1,
	parameter int DELAY_CYC_2 = PGC_RELEASE_CYC_2,
	parameter int DELAY_CYC_3 = PGC_RELEASE_CYC_3
)
(
	input  wire logic    i_clk_sys,
	input  wire logic    i_arst_n,
	pgc_delay_if.timer   dly
);

	typedef struct packed
	{
		pgc_tm_state_t              state;
		logic [PGC_DELAY_WIDTH-1:0] count;
		logic                       low;
	} pgc_tm_regs_t;

	localparam pgc_tm_regs_t TM_RESET = '{state: PGC_TM_HOLD, count: '0, low: 1'b1};

	pgc_tm_regs_t r;
	pgc_tm_regs_t next_r;
	logic [PGC_DELAY_WIDTH-1:0] load_value;

	// Delay chosen by the factory code; counted down after the hold drops
	always_comb
	begin
		case (dly.delay_code)
			PGC_DLY_CODE_0: load_value = PGC_DELAY_WIDTH'(DELAY_CYC_0 - 1);
			PGC_DLY_CODE_1: load_value = PGC_DELAY_WIDTH'(DELAY_CYC_1 - 1);
			PGC_DLY_CODE_2: load_value = PGC_DELAY_WIDTH'(DELAY_CYC_2 - 1);
			default:        load_value = PGC_DELAY_WIDTH'(DELAY_CYC_3 - 1);
		endcase
	end

	// Any new hold restarts the full delay, so short glitches cannot shorten it
	always_comb
	begin
		next_r = r;
		case (r.state)
			PGC_TM_IDLE:
			begin
				if (dly.hold)
				begin
					next_r.state = PGC_TM_HOLD;
					next_r.low   = 1'b1;
				end
			end
			PGC_TM_HOLD:
			begin
				next_r.low = 1'b1;
				if (!dly.hold)
				begin
					next_r.state = PGC_TM_COUNT;
					next_r.count = load_value;
				end
			end
			PGC_TM_COUNT:
			begin
				if (dly.hold)
				begin
					next_r.state = PGC_TM_HOLD;
				end
				else if (r.count == '0)
				begin
					next_r.state = PGC_TM_IDLE;
					next_r.low   = 1'b0;
				end
				else
				begin
					next_r.count = r.count - 1'b1;
				end
			end
			default:
			begin
				next_r = TM_RESET;
			end
		endcase
	end

	// State register; the line stays low through reset and the whole delay
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			r <= TM_RESET;
		else
			r <= next_r;
	end

	assign dly.line_low = r.low;

endmodule
`default_nettype wire

/* File: pgc_checker.sv */
// Concurrent checks for the global configuration block.
// Assumes it is bound to pgc_global_config and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module pgc_checker
	import pgc_pkg::*;
#(
	parameter logic       OPT_WAKE_ZERO_ACTIVE_LOW = 1'b0,
	parameter logic       OPT_WD_ENABLE_LOCK       = 1'b0,
	parameter logic       OPT_WD_PERIOD_LOCK       = 1'b0,
	parameter logic       OPT_MANUAL_RESET_REWAKE  = 1'b0,
	parameter logic [7:0] SERIAL_NUMBER_LOW        = 8'h5A
)
(
	input wire logic       i_clk_sys,
	input wire logic       i_arst_n,
	input wire logic [6:0] i_bus_dev_addr,
	input wire logic [7:0] i_bus_reg_addr,
	input wire logic       i_bus_wr,
	input wire logic       i_bus_rd,
	input wire logic [7:0] i_bus_wdata,
	input wire logic [7:0] o_bus_rdata,
	input wire logic       o_bus_ack,
	input wire logic       i_wake_input_zero,
	input wire logic       i_reset_request,
	input wire logic       i_global_shutdown,
	input wire logic       i_power_off_function,
	input wire logic       i_manual_reset_shutdown,
	input wire logic       o_bidir_reset_line_oe,
	input wire logic       o_wake_zero_active,
	input wire logic       o_self_wake,
	input wire logic [2:0] o_battery_threshold,
	input wire logic       o_watchdog_enable,
	input wire logic [1:0] o_watchdog_period
);
	logic       sel;
	logic       stop_ev;
	logic [2:0] wr_thr;

	// Threshold field of the write data, sampled as a whole signal by $past
	assign wr_thr = i_bus_wdata[PGC_THR_MSB:PGC_THR_LSB];

	// Selected access and the only events allowed to stop a locked watchdog
	assign sel     = (i_bus_wr | i_bus_rd) && (i_bus_dev_addr == PGC_DEV_ADDR);
	assign stop_ev = i_global_shutdown | i_power_off_function;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_arst_n);

	a_ack_follows_access: assert property (sel |=> o_bus_ack)
		else $error("no ack after a selected access");
	a_foreign_no_ack: assert property (!sel |=> !o_bus_ack)
		else $error("ack without a selected access");
	a_serial_fixed: assert property (sel && i_bus_rd && i_bus_reg_addr == PGC_SERIAL_ADDR
		|=> o_bus_rdata == SERIAL_NUMBER_LOW) else $error("serial byte changed");
	a_wd_lock_hold: assert property (OPT_WD_ENABLE_LOCK && o_watchdog_enable && !stop_ev
		|=> o_watchdog_enable) else $error("locked watchdog enable dropped");
	a_wd_stop_clears: assert property (stop_ev |=> !o_watchdog_enable)
		else $error("watchdog enable survived shutdown");
	a_period_locked: assert property (OPT_WD_PERIOD_LOCK && o_watchdog_enable
		|=> $stable(o_watchdog_period)) else $error("locked period changed");
	a_threshold_written: assert property (sel && i_bus_wr && i_bus_reg_addr == PGC_CFG1_ADDR
		|=> o_battery_threshold == $past(wr_thr)) else $error("threshold mismatch");
	a_self_wake_pulse: assert property (i_manual_reset_shutdown
		|=> o_self_wake == OPT_MANUAL_RESET_REWAKE) else $error("self wake wrong");
	a_wake_polarity: assert property ($stable(i_wake_input_zero)[*5]
		|-> o_wake_zero_active == (i_wake_input_zero ^ OPT_WAKE_ZERO_ACTIVE_LOW))
		else $error("wake polarity wrong");
	a_reset_held: assert property (i_reset_request |=> o_bidir_reset_line_oe[*8])
		else $error("reset line released too early");

	// Main scenarios reached
	c_cfg_write: cover property (sel && i_bus_wr && i_bus_reg_addr == PGC_CFG1_ADDR);
	c_reset_release: cover property ($fell(o_bidir_reset_line_oe));
	c_self_wake: cover property (o_self_wake);
endmodule

bind pgc_global_config pgc_checker #(
	.OPT_WAKE_ZERO_ACTIVE_LOW(OPT_WAKE_ZERO_ACTIVE_LOW), .OPT_WD_ENABLE_LOCK(OPT_WD_ENABLE_LOCK),
	.OPT_WD_PERIOD_LOCK(OPT_WD_PERIOD_LOCK), .OPT_MANUAL_RESET_REWAKE(OPT_MANUAL_RESET_REWAKE),
	.SERIAL_NUMBER_LOW(SERIAL_NUMBER_LOW)
) u_pgc_checker (
	.i_clk_sys, .i_arst_n, .i_bus_dev_addr, .i_bus_reg_addr, .i_bus_wr, .i_bus_rd,
	.i_bus_wdata, .o_bus_rdata, .o_bus_ack, .i_wake_input_zero, .i_reset_request,
	.i_global_shutdown, .i_power_off_function, .i_manual_reset_shutdown,
	.o_bidir_reset_line_oe, .o_wake_zero_active, .o_self_wake, .o_battery_threshold,
	.o_watchdog_enable, .o_watchdog_period
);
`default_nettype wire

/* File: pgc_host_model.sv */
// Host processor model issuing decoded register accesses.
// Assumes one access at a time, launched at the falling clock edge.
`timescale 1ns/10ps
`default_nettype none
module pgc_host_model
	import pgc_pkg::*;
(
	input  wire logic       i_clk_sys,
	input  wire logic       i_ack,
	input  wire logic [7:0] i_rdata,
	output logic [6:0]      o_dev_addr,
	output logic [7:0]      o_reg_addr,
	output logic            o_wr,
	output logic            o_rd,
	output logic [7:0]      o_wdata
);
	// Idle bus at time zero
	initial
	begin
		o_dev_addr = 7'h00;
		o_reg_addr = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_wdata = 8'h00;
	end

	// One strobe cycle, answer taken after the ack edge; register address and write data flip so stale values show
	task automatic xfer(input logic [6:0] dev, input logic [7:0] a, input logic w,
		input logic [7:0] d, output logic [7:0] rdv, output logic ackv);
		@(negedge i_clk_sys);
		o_dev_addr = dev;
		o_reg_addr = a;
		o_wr = w;
		o_rd = !w;
		o_wdata = (w && a == PGC_CFG1_ADDR) ? (d | 8'h80) : d;
		@(negedge i_clk_sys);
		rdv = i_rdata;
		ackv = i_ack;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_reg_addr = ~a;
		o_wdata = ~o_wdata;
	endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench: registers, watchdog locks, pin polarity, battery and reset line.
// Assumes the host model owns the register bus; all other pins are driven here.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import pgc_pkg::*;
	localparam int         DLY = 40;     // Shortened release delay for code 1
	localparam logic [4:0] POL = 5'h15;  // Order: wake0, wake1, adapter, cover, power-down
	logic       clk = 1'b0;
	logic       arst_n = 1'b0;
	logic [4:0] pins = 5'h00;
	logic       batt = 1'b0;
	logic       slow = 1'b0;
	logic       rreq = 1'b0;
	logic       gsd = 1'b0;
	logic       poff = 1'b0;
	logic       mrs = 1'b0;
	logic       fclr = 1'b0;
	logic [6:0] dev;
	logic [7:0] reg_a, wdata, rdata, got;
	logic       wr, rd, ack, gack, rst_o, rst_oe, rst_lvl, clk_o, clk_oe;
	logic       st, flag, sdreq, swake, wden;
	logic [4:0] qual;
	logic [1:0] hyst, wdper;
	logic [2:0] thr;
	logic       rst_oe2, clk_o2, clk_oe2, swake2, wden2;
	logic [4:0] qual2;
	logic [1:0] wdper2;
	logic [4:0] pat [3] = '{5'h00, 5'h1F, 5'h0A};
	int         failures = 0;
	int         tests_run = 0;
	int         cycles = 0;
	int         n;

	always #5 clk = ~clk;

	// Open-drain reset wire with a pull-up
	pgc_global_config #(
		.OPT_SLOW_CLOCK_OPEN_DRAIN(1'b1), .OPT_WAKE_ZERO_ACTIVE_LOW(POL[4]),
		.OPT_WAKE_ONE_ACTIVE_LOW(POL[3]), .OPT_ADAPTER_ACTIVE_LOW(POL[2]),
		.OPT_COVER_ACTIVE_LOW(POL[1]), .OPT_POWER_DOWN_ACTIVE_LOW(POL[0]),
		.OPT_WD_ENABLE_LOCK(1'b1), .OPT_WD_PERIOD_LOCK(1'b1), .OPT_RELEASE_DELAY(2'h1),
		.OPT_MANUAL_RESET_REWAKE(1'b1), .DELAY_CYC_1(DLY)
	) u_pgc_global_config (
		.i_clk_sys(clk), .i_arst_n(arst_n), .i_bus_dev_addr(dev), .i_bus_reg_addr(reg_a),
		.i_bus_wr(wr), .i_bus_rd(rd), .i_bus_wdata(wdata), .o_bus_rdata(rdata), .o_bus_ack(ack),
		.i_wake_input_zero(pins[4]), .i_wake_input_one(pins[3]),
		.i_adapter_present_input(pins[2]), .i_cover_closed_input(pins[1]),
		.i_power_down_input(pins[0]), .i_battery_below_threshold(batt), .i_slow_clock(slow),
		.i_bidir_reset_line_i(rst_oe ? rst_o : 1'b1), .o_bidir_reset_line_o(rst_o),
		.o_bidir_reset_line_oe(rst_oe), .o_slow_clock_output_o(clk_o),
		.o_slow_clock_output_oe(clk_oe), .i_reset_request(rreq), .i_global_shutdown(gsd),
		.i_power_off_function(poff), .i_manual_reset_shutdown(mrs), .i_battery_flag_clear(fclr),
		.o_wake_zero_active(qual[4]), .o_wake_one_active(qual[3]), .o_adapter_present(qual[2]),
		.o_cover_closed(qual[1]), .o_power_down_request(qual[0]), .o_battery_low_status(st),
		.o_battery_low_interrupt_flag(flag), .o_global_shutdown_request(sdreq),
		.o_self_wake(swake), .o_reset_line_level(rst_lvl), .o_battery_hysteresis(hyst),
		.o_battery_threshold(thr), .o_watchdog_enable(wden), .o_watchdog_period(wdper)
	);

	// Second unit keeps every option at its default: push-pull, active-high, unlocked, code 0
	pgc_global_config #(
		.DELAY_CYC_0(DLY / 2)
	) u_pgc_global_config_dflt (
		.i_clk_sys(clk), .i_arst_n(arst_n), .i_bus_dev_addr(dev), .i_bus_reg_addr(reg_a),
		.i_bus_wr(wr), .i_bus_rd(rd), .i_bus_wdata(wdata), .o_bus_rdata(), .o_bus_ack(),
		.i_wake_input_zero(pins[4]), .i_wake_input_one(pins[3]),
		.i_adapter_present_input(pins[2]), .i_cover_closed_input(pins[1]),
		.i_power_down_input(pins[0]), .i_battery_below_threshold(batt), .i_slow_clock(slow),
		.i_bidir_reset_line_i(!rst_oe2), .o_bidir_reset_line_o(), .o_bidir_reset_line_oe(rst_oe2),
		.o_slow_clock_output_o(clk_o2), .o_slow_clock_output_oe(clk_oe2), .i_reset_request(rreq),
		.i_global_shutdown(gsd), .i_power_off_function(poff), .i_manual_reset_shutdown(mrs),
		.i_battery_flag_clear(fclr), .o_wake_zero_active(qual2[4]), .o_wake_one_active(qual2[3]),
		.o_adapter_present(qual2[2]), .o_cover_closed(qual2[1]), .o_power_down_request(qual2[0]),
		.o_battery_low_status(), .o_battery_low_interrupt_flag(), .o_global_shutdown_request(),
		.o_self_wake(swake2), .o_reset_line_level(), .o_battery_hysteresis(),
		.o_battery_threshold(), .o_watchdog_enable(wden2), .o_watchdog_period(wdper2)
	);

	pgc_host_model u_pgc_host_model (
		.i_clk_sys(clk), .i_ack(ack), .i_rdata(rdata), .o_dev_addr(dev),
		.o_reg_addr(reg_a), .o_wr(wr), .o_rd(rd), .o_wdata(wdata)
	);

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		u_pgc_host_model.xfer(PGC_DEV_ADDR, a, 1'b1, d, got, gack);
	endtask

	// Read must be acknowledged as well as carry the expected byte
	task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
		u_pgc_host_model.xfer(PGC_DEV_ADDR, a, 1'b0, 8'h00, got, gack);
		check({7'h00, gack}, 8'h01);
		check(got, exp);
	endtask

	// One-cycle pulse launched at a falling edge
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask

	task automatic count_sd();
		n = 0;
		repeat (8)
		begin
			@(negedge clk);
			if (sdreq === 1'b1)
				n++;
		end
	endtask

	// Hang guard: the whole run needs well under a thousand cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failures++;
			summarize();
		end
	end

	initial
	begin
		repeat (3) @(negedge clk);
		arst_n = 1'b1;
		@(negedge clk);
		check({7'h00, rst_oe}, 8'h01);
		rreg(PGC_CFG1_ADDR, 8'h92);
		rreg(PGC_WDOG_ADDR, 8'h03);
		rreg(8'h10, 8'h00);
		wreg(PGC_SERIAL_ADDR, 8'hFF);
		rreg(PGC_SERIAL_ADDR, 8'h5A);
		u_pgc_host_model.xfer(7'h3D, PGC_CFG1_ADDR, 1'b0, 8'h00, got, gack);
		check({7'h00, gack}, 8'h00);
		$display("test registers done");
		wreg(PGC_WDOG_ADDR, 8'h05);
		rreg(PGC_WDOG_ADDR, 8'h05);
		wreg(PGC_WDOG_ADDR, 8'h02);
		rreg(PGC_WDOG_ADDR, 8'h05);
		check({5'h00, wden2, wdper2}, 8'h02);
		pulse(gsd);
		rreg(PGC_WDOG_ADDR, 8'h01);
		wreg(PGC_WDOG_ADDR, 8'h06);
		check({5'h00, wden, wdper}, 8'h06);
		pulse(poff);
		check({7'h00, wden}, 8'h00);
		$display("test watchdog done");
		foreach (pat[i])
		begin
			pins = pat[i];
			slow = ~slow;
			repeat (5) @(negedge clk);
			check({3'h0, qual}, {3'h0, pat[i] ^ POL});
			check({6'h00, clk_o, clk_oe}, {7'h00, ~slow});
			check({3'h0, qual2}, {3'h0, pat[i]});
			check({6'h00, clk_o2, clk_oe2}, {6'h00, slow, 1'b1});
		end
		$display("test pins done");
		wreg(PGC_CFG1_ADDR, 8'h7B);
		check({3'h0, hyst, thr}, 8'h1D);
		rreg(PGC_CFG1_ADDR, 8'hFB);
		batt = 1'b1;
		count_sd();
		check(n[7:0], 8'h01);
		check({5'h00, st, flag, rst_oe}, 8'h07);
		pulse(fclr);
		@(negedge clk);
		check({7'h00, flag}, 8'h00);
		batt = 1'b0;
		repeat (DLY + 10) @(negedge clk);
		check({7'h00, rst_oe}, 8'h00);
		wreg(PGC_CFG1_ADDR, 8'h0A);
		batt = 1'b1;
		count_sd();
		check(n[7:0], 8'h00);
		check({5'h00, st, flag, rst_oe}, 8'h06);
		batt = 1'b0;
		$display("test battery done");
		rreq = 1'b1;
		repeat (5) @(negedge clk);
		check({5'h00, rst_o, rst_oe, rst_lvl}, 8'h02);
		rreq = 1'b0;
		// The default unit counts the shorter code-zero delay and must be free by now
		repeat (DLY / 2 + 3) @(negedge clk);
		check({6'h00, rst_oe2, rst_oe}, 8'h01);
		n = DLY / 2 + 3;
		while (rst_oe === 1'b1 && n < 200)
		begin
			@(negedge clk);
			n++;
		end
		check({7'h00, n >= DLY && n <= DLY + 3}, 8'h01);
		pulse(mrs);
		check({7'h00, swake}, 8'h01);
		check({7'h00, swake2}, 8'h00);
		$display("test reset and wake done");
		summarize();
	end
endmodule
`default_nettype wire
